// ===== verilog/ebx_pkg.sv
// Purpose: Shared constants and types for the exchange and block-copy executor
// Assumes: Byte-wide memory, 16-bit register pairs, flags in the low byte of the pair
// Notes: Opcode values and machine-cycle counts are the architectural ones
`default_nettype none
package ebx_pkg;
  // Opcode and prefix bytes
  localparam logic [7:0] PFX_NONE = 8'h00;
  localparam logic [7:0] PFX_EXT = 8'hed;
  localparam logic [7:0] PFX_FIRST = 8'hdd;
  localparam logic [7:0] PFX_SECOND = 8'hfd;
  localparam logic [7:0] OP_SWAP_PAIRS = 8'heb;
  localparam logic [7:0] OP_SWAP_AF = 8'h08;
  localparam logic [7:0] OP_BANK_SWAP = 8'hd9;
  localparam logic [7:0] OP_STACK_SWAP = 8'he3;
  localparam logic [7:0] OP_COPY_INC = 8'ha0;
  localparam logic [7:0] OP_COPY_INC_REPEAT = 8'hb0;
  // Flag bit positions in the flag byte
  localparam int FLAG_S = 7;
  localparam int FLAG_Z = 6;
  localparam int FLAG_H = 4;
  localparam int FLAG_PV = 2;
  localparam int FLAG_N = 1;
  localparam int FLAG_C = 0;
  // Machine cycles per instruction, opcode fetches included
  localparam logic [3:0] MC_REG_SWAP = 4'h1;
  localparam logic [3:0] MC_STACK_SWAP = 4'h5;
  localparam logic [3:0] MC_STACK_SWAP_OFS = 4'h6;
  localparam logic [3:0] MC_COPY = 4'h4;
  localparam logic [3:0] MC_COPY_AGAIN = 4'h5;
  localparam logic [1:0] REFRESH_COUNT = 2'h2;
  localparam logic [15:0] PC_REWIND = 16'h0002;
  localparam int FIFO_WORDS = 16;
  // Which pair a stack swap works on
  localparam logic [1:0] SEL_SOURCE = 2'h0;
  localparam logic [1:0] SEL_FIRST_OFS = 2'h1;
  localparam logic [1:0] SEL_SECOND_OFS = 2'h2;

  typedef struct packed {
    logic [15:0] accum_flags_pair;
    logic [15:0] byte_count_pair;
    logic [15:0] target_ptr_pair;
    logic [15:0] source_pair;
    logic [15:0] shadow_accum_flags_pair;
    logic [15:0] shadow_byte_count_pair;
    logic [15:0] shadow_target_ptr_pair;
    logic [15:0] shadow_source_pair;
    logic [15:0] first_offset_reg;
    logic [15:0] second_offset_reg;
    logic [15:0] stack_ptr;
    logic [15:0] prog_ctr;
  } ebx_regs_t;

  localparam ebx_regs_t REGS_RESET = '0;

  typedef struct packed {
    logic we;
    logic [15:0] addr;
    logic [7:0] wdata;
  } ebx_mem_req_t;

  localparam ebx_mem_req_t MEM_REQ_RESET = '0;

  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_RD_LO = 8'h02,
    ST_RD_HI = 8'h04,
    ST_WR_LO = 8'h08,
    ST_WR_HI = 8'h10,
    ST_CP_RD = 8'h20,
    ST_CP_WR = 8'h40,
    ST_REFRESH = 8'h80
  } ebx_state_t;
endpackage
`default_nettype wire

// ===== verilog/ebx_fifo.sv
// Purpose: Read-data buffer between the memory return path and the executor
// Assumes: One clock, valid/ready on both sides
// Notes: Depth must be a power of two
`default_nettype none
module ebx_fifo
  import ebx_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = FIFO_WORDS
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic push;
  logic pop;

  assign in_ready = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
  assign out_valid = wr_ptr != rd_ptr;
  assign out_data = mem[rd_ptr[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge mclk)
  begin
    if (push)
    begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop)
      begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== verilog/ebx_exec.sv
// Purpose: Executes register swaps, stack swaps and the incrementing block copy
// Assumes: Memory takes a request on mem_valid && mem_ready; read bytes return on mem_rvalid
// Notes: One iteration of the repeating copy per command; the core refetches via the rewound counter
// Function
// - Opcode EB swaps the target pointer pair and source pair.
// - Opcode 08 swaps the accumulator-flags pair with its shadow copy.
// - Opcode D9 swaps counter, target and source pairs with shadow copies at once.
// - Stack swap E3 trades source pair bytes with stack memory, five machine cycles.
// - Prefix DD stack swap trades first offset register bytes, six machine cycles.
// - Prefix FD stack swap does the same with the second offset register.
// - Swaps other than 08 change no flag; stack swaps keep the stack pointer.
// - Copy A0 reads at source pair, writes at target pointer, four cycles.
// - After each copy, both pointers increment and the byte counter decrements.
// - Single copy clears H and N, sets parity when counter nonzero.
// - Repeating copy ends when the decremented counter is zero.
// - Nonzero counter rewinds the program counter by two for refetch.
// - Interrupts accepted and two refresh cycles after each repeating byte that leaves the counter nonzero.
// - A zero counter at start wraps, moving a full 64K bytes.
// - Repeating copy is decoded only behind the extended prefix ED.
// - Repeating copy clears H, parity and N; S, Z, C untouched.
// - Repeating iteration takes five machine cycles, the final one four.
`default_nettype none
module ebx_exec
  import ebx_pkg::*;
#(
  parameter int FIFO_DEPTH = FIFO_WORDS
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Register file load
  input wire logic regs_load,
  input wire ebx_regs_t regs_in,
  output ebx_regs_t regs,
  // Instruction command
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [7:0] cmd_prefix,
  input wire logic [7:0] cmd_opcode,
  // Completion
  output logic done,
  output logic [3:0] done_mcycles,
  output logic illegal,
  output logic int_window,
  output logic refresh,
  // Memory requests
  output logic mem_valid,
  input wire logic mem_ready,
  output ebx_mem_req_t mem_req,
  // Memory read return
  input wire logic mem_rvalid,
  output logic mem_rready,
  input wire logic [7:0] mem_rdata
);
  ebx_state_t state;
  logic issued;
  logic [1:0] sel;
  logic repeat_op;
  logic [7:0] byte_lo, byte_hi;
  logic [1:0] refresh_left;
  logic rd_valid, rd_take;
  logic [7:0] rd_data;
  logic accept;
  logic [15:0] swap_val, next_count;
  logic [7:0] copy_flags;
  logic copy_more;

  // Pair selected for a stack swap
  function automatic logic [15:0] pick_pair(input ebx_regs_t r, input logic [1:0] s);
    case (s)
      SEL_FIRST_OFS: pick_pair = r.first_offset_reg;
      SEL_SECOND_OFS: pick_pair = r.second_offset_reg;
      default: pick_pair = r.source_pair;
    endcase
  endfunction
  assign cmd_ready = (state == ST_IDLE) && !regs_load;
  assign accept = cmd_valid && cmd_ready;
  assign swap_val = pick_pair(regs, sel);
  assign next_count = regs.byte_count_pair - 16'h0001;
  assign copy_more = next_count != 16'h0000;
  // H and N cleared; the repeating form also clears parity
  assign copy_flags = {regs.accum_flags_pair[7:5], 1'b0, regs.accum_flags_pair[3],
    copy_more && !repeat_op, 1'b0, regs.accum_flags_pair[0]};
  assign mem_valid = !issued && (state == ST_RD_LO || state == ST_RD_HI || state == ST_WR_LO
    || state == ST_WR_HI || state == ST_CP_RD || state == ST_CP_WR);
  assign rd_take = rd_valid && issued && (state == ST_RD_LO || state == ST_RD_HI || state == ST_CP_RD);
  // Read bytes are buffered so memory never stalls on a slow consumer
  ebx_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_rd_fifo (
    .mclk(mclk),
    .resetn(resetn),
    .in_valid(mem_rvalid),
    .in_ready(mem_rready),
    .in_data(mem_rdata),
    .out_valid(rd_valid),
    .out_ready(rd_take),
    .out_data(rd_data)
  );

  // Sequencer and memory requests
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      state <= ST_IDLE;
      issued <= 1'b0;
      sel <= SEL_SOURCE;
      repeat_op <= 1'b0;
      byte_lo <= 8'h00;
      byte_hi <= 8'h00;
      refresh_left <= 2'h0;
      mem_req <= MEM_REQ_RESET;
    end
    else
    begin
      if (mem_valid && mem_ready)
        issued <= 1'b1;
      case (state)
        ST_IDLE:
        begin
          issued <= 1'b0;
          if (accept && cmd_opcode == OP_STACK_SWAP &&
            (cmd_prefix == PFX_NONE || cmd_prefix == PFX_FIRST || cmd_prefix == PFX_SECOND))
          begin
            sel <= (cmd_prefix == PFX_FIRST) ? SEL_FIRST_OFS :
              (cmd_prefix == PFX_SECOND) ? SEL_SECOND_OFS : SEL_SOURCE;
            mem_req <= '{we: 1'b0, addr: regs.stack_ptr, wdata: 8'h00};
            state <= ST_RD_LO;
          end
          else if (accept && cmd_prefix == PFX_EXT &&
            (cmd_opcode == OP_COPY_INC || cmd_opcode == OP_COPY_INC_REPEAT))
          begin
            repeat_op <= cmd_opcode == OP_COPY_INC_REPEAT;
            mem_req <= '{we: 1'b0, addr: regs.source_pair, wdata: 8'h00};
            state <= ST_CP_RD;
          end
        end
        ST_RD_LO:
        begin
          if (rd_take)
          begin
            byte_lo <= rd_data;
            issued <= 1'b0;
            mem_req <= '{we: 1'b0, addr: regs.stack_ptr + 16'h0001, wdata: 8'h00};
            state <= ST_RD_HI;
          end
        end
        ST_RD_HI:
        begin
          // Both stack bytes are held before any write-back
          if (rd_take)
          begin
            byte_hi <= rd_data;
            issued <= 1'b0;
            mem_req <= '{we: 1'b1, addr: regs.stack_ptr, wdata: swap_val[7:0]};
            state <= ST_WR_LO;
          end
        end
        ST_WR_LO:
        begin
          if (mem_valid && mem_ready)
          begin
            issued <= 1'b0;
            mem_req <= '{we: 1'b1, addr: regs.stack_ptr + 16'h0001, wdata: swap_val[15:8]};
            state <= ST_WR_HI;
          end
        end
        ST_WR_HI:
        begin
          if (mem_valid && mem_ready)
          begin
            issued <= 1'b0;
            state <= ST_IDLE;
          end
        end
        ST_CP_RD:
        begin
          if (rd_take)
          begin
            issued <= 1'b0;
            mem_req <= '{we: 1'b1, addr: regs.target_ptr_pair, wdata: rd_data};
            state <= ST_CP_WR;
          end
        end
        ST_CP_WR:
        begin
          if (mem_valid && mem_ready)
          begin
            issued <= 1'b0;
            if (repeat_op && copy_more)
            begin
              refresh_left <= REFRESH_COUNT;
              state <= ST_REFRESH;
            end
            else
              state <= ST_IDLE;
          end
        end
        ST_REFRESH:
        begin
          refresh_left <= refresh_left - 2'h1;
          if (refresh_left == 2'h1)
            state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Architectural registers
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      regs <= REGS_RESET;
    else if (regs_load && state == ST_IDLE)
      regs <= regs_in;
    else if (accept && cmd_prefix == PFX_NONE)
    begin
      case (cmd_opcode)
        OP_SWAP_PAIRS:
        begin
          regs.target_ptr_pair <= regs.source_pair;
          regs.source_pair <= regs.target_ptr_pair;
        end
        OP_SWAP_AF:
        begin
          regs.accum_flags_pair <= regs.shadow_accum_flags_pair;
          regs.shadow_accum_flags_pair <= regs.accum_flags_pair;
        end
        OP_BANK_SWAP:
        begin
          regs.byte_count_pair <= regs.shadow_byte_count_pair;
          regs.shadow_byte_count_pair <= regs.byte_count_pair;
          regs.target_ptr_pair <= regs.shadow_target_ptr_pair;
          regs.shadow_target_ptr_pair <= regs.target_ptr_pair;
          regs.source_pair <= regs.shadow_source_pair;
          regs.shadow_source_pair <= regs.source_pair;
        end
        default: regs <= regs;
      endcase
    end
    else if (state == ST_WR_HI && mem_valid && mem_ready)
    begin
      // Stack pointer and flags are left alone
      case (sel)
        SEL_FIRST_OFS: regs.first_offset_reg <= {byte_hi, byte_lo};
        SEL_SECOND_OFS: regs.second_offset_reg <= {byte_hi, byte_lo};
        default: regs.source_pair <= {byte_hi, byte_lo};
      endcase
    end
    else if (state == ST_CP_WR && mem_valid && mem_ready)
    begin
      regs.source_pair <= regs.source_pair + 16'h0001;
      regs.target_ptr_pair <= regs.target_ptr_pair + 16'h0001;
      regs.byte_count_pair <= next_count;
      regs.accum_flags_pair[7:0] <= copy_flags;
      if (repeat_op && copy_more)
        regs.prog_ctr <= regs.prog_ctr - PC_REWIND;
    end
  end

  // Completion reporting
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      done <= 1'b0;
      done_mcycles <= 4'h0;
      illegal <= 1'b0;
      int_window <= 1'b0;
      refresh <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      illegal <= 1'b0;
      int_window <= 1'b0;
      refresh <= state == ST_REFRESH;
      if (accept && cmd_prefix == PFX_NONE &&
        (cmd_opcode == OP_SWAP_PAIRS || cmd_opcode == OP_SWAP_AF || cmd_opcode == OP_BANK_SWAP))
      begin
        done <= 1'b1;
        done_mcycles <= MC_REG_SWAP;
      end
      else if (accept && !(cmd_opcode == OP_STACK_SWAP &&
        (cmd_prefix == PFX_NONE || cmd_prefix == PFX_FIRST || cmd_prefix == PFX_SECOND)) &&
        !(cmd_prefix == PFX_EXT && (cmd_opcode == OP_COPY_INC || cmd_opcode == OP_COPY_INC_REPEAT)))
        illegal <= 1'b1;
      if (state == ST_WR_HI && mem_valid && mem_ready)
      begin
        done <= 1'b1;
        done_mcycles <= (sel == SEL_SOURCE) ? MC_STACK_SWAP : MC_STACK_SWAP_OFS;
      end
      if (state == ST_CP_WR && mem_valid && mem_ready && !(repeat_op && copy_more))
      begin
        done <= 1'b1;
        done_mcycles <= MC_COPY;
      end
      if (state == ST_REFRESH && refresh_left == 2'h1)
      begin
        done <= 1'b1;
        int_window <= 1'b1;
        done_mcycles <= MC_COPY_AGAIN;
      end
    end
  end

  // Snapshot of registers at command acceptance, read only by the checks
  ebx_regs_t start_regs;
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      start_regs <= REGS_RESET;
    else if (accept)
      start_regs <= regs;
  end
  swap_pairs_a: assert property (@(posedge mclk) disable iff (!resetn)
    accept && cmd_prefix == PFX_NONE && cmd_opcode == OP_SWAP_PAIRS |=>
    regs.target_ptr_pair == $past(regs.source_pair) && regs.source_pair == $past(regs.target_ptr_pair))
    else $error("pair swap wrong");
  swap_accum_a: assert property (@(posedge mclk) disable iff (!resetn)
    accept && cmd_prefix == PFX_NONE && cmd_opcode == OP_SWAP_AF |=>
    regs.accum_flags_pair == $past(regs.shadow_accum_flags_pair) && done && done_mcycles == MC_REG_SWAP)
    else $error("accumulator swap wrong");
  bank_swap_a: assert property (@(posedge mclk) disable iff (!resetn)
    accept && cmd_prefix == PFX_NONE && cmd_opcode == OP_BANK_SWAP |=>
    regs.shadow_byte_count_pair == $past(regs.byte_count_pair) &&
    regs.source_pair == $past(regs.shadow_source_pair))
    else $error("bank swap wrong");
  stack_load_a: assert property (@(posedge mclk) disable iff (!resetn)
    state == ST_WR_HI && mem_valid && mem_ready |=> swap_val == {byte_hi, byte_lo} &&
    done && done_mcycles == ((sel == SEL_SOURCE) ? MC_STACK_SWAP : MC_STACK_SWAP_OFS))
    else $error("stack swap load wrong");
  offset_sel_a: assert property (@(posedge mclk) disable iff (!resetn)
    accept && cmd_opcode == OP_STACK_SWAP && cmd_prefix == PFX_FIRST |=> sel == SEL_FIRST_OFS)
    else $error("offset select wrong");
  stack_keep_a: assert property (@(posedge mclk) disable iff (!resetn)
    done && !$past(regs_load) && $past(state) == ST_WR_HI |->
    regs.stack_ptr == start_regs.stack_ptr && regs.accum_flags_pair == start_regs.accum_flags_pair)
    else $error("stack swap changed pointer or flags");
  read_first_a: assert property (@(posedge mclk) disable iff (!resetn)
    $rose(state == ST_WR_LO) |-> $past(state, 1) == ST_RD_HI && mem_req.we)
    else $error("stack write before both reads");
  copy_step_a: assert property (@(posedge mclk) disable iff (!resetn)
    state == ST_CP_WR && mem_valid && mem_ready |=>
    regs.source_pair == start_regs.source_pair + 16'h0001 &&
    regs.byte_count_pair == start_regs.byte_count_pair - 16'h0001)
    else $error("copy pointer update wrong");
  copy_flags_a: assert property (@(posedge mclk) disable iff (!resetn)
    state == ST_CP_WR && mem_valid && mem_ready |=>
    regs.accum_flags_pair[FLAG_PV] == (!repeat_op && regs.byte_count_pair != 16'h0000) &&
    !regs.accum_flags_pair[FLAG_H] && !regs.accum_flags_pair[FLAG_N])
    else $error("copy flags wrong");
  rewind_a: assert property (@(posedge mclk) disable iff (!resetn)
    state == ST_CP_WR && mem_valid && mem_ready && repeat_op && copy_more |=>
    regs.prog_ctr == start_regs.prog_ctr - PC_REWIND ##1 refresh ##1 refresh && int_window && done)
    else $error("repeat rewind or refresh wrong");
  cover_stack_swap_c: cover property (@(posedge mclk) disable iff (!resetn)
    done && done_mcycles == MC_STACK_SWAP_OFS);
  cover_repeat_c: cover property (@(posedge mclk) disable iff (!resetn) int_window);
  cover_copy_end_c: cover property (@(posedge mclk) disable iff (!resetn)
    done && done_mcycles == MC_COPY);
endmodule
`default_nettype wire

// ===== tb/ebx_mem_model.sv
// Purpose: Byte-wide memory on the far side of the executor's request and return ports
// Assumes: One outstanding request; read data held until the return side takes it
// Notes: Slow mode accepts one request in four cycles and delays the return
`default_nettype none
module ebx_mem_model
  import ebx_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  input wire logic slow,
  // Requests
  input wire logic mem_valid,
  output logic mem_ready,
  input wire ebx_mem_req_t mem_req,
  // Read return
  output logic mem_rvalid,
  input wire logic mem_rready,
  output logic [7:0] mem_rdata
);
  logic [7:0] mem [0:65535];
  logic [1:0] tick;
  logic [7:0] held;
  logic pend;
  assign mem_ready = !slow || (tick == 2'h3);
  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      tick <= 2'h0;
      pend <= 1'b0;
      mem_rvalid <= 1'b0;
      mem_rdata <= 8'h5a;
    end
    else
    begin
      tick <= tick + 2'h1;
      if (mem_valid && mem_ready && mem_req.we)
        mem[mem_req.addr] <= mem_req.wdata;
      if (mem_valid && mem_ready && !mem_req.we)
      begin
        pend <= 1'b1;
        held <= mem[mem_req.addr];
      end
      if (pend && !mem_rvalid && (!slow || tick == 2'h1))
      begin
        pend <= 1'b0;
        mem_rvalid <= 1'b1;
        mem_rdata <= held;
      end
      else if (!mem_rvalid || mem_rready)
      begin
        // Idle data keeps changing so a stale byte is never mistaken for fresh
        mem_rvalid <= 1'b0;
        mem_rdata <= ~mem_rdata;
      end
    end
  end
endmodule
`default_nettype wire

// ===== tb/testbench.sv
// Purpose: Self-checking bench for the exchange and block-copy executor
// Assumes: Inputs change on the falling edge and results are read there
// Notes: FIFO depth cut to 4; the return buffer is exercised only through the design's own reads
`default_nettype none
module testbench
  import ebx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic regs_load = 1'b0;
  logic cmd_valid = 1'b0;
  logic slow = 1'b0;
  logic [7:0] cmd_prefix = 8'h00;
  logic [7:0] cmd_opcode = 8'h00;
  ebx_regs_t regs_in = '0;
  ebx_regs_t regs;
  ebx_regs_t e;
  logic cmd_ready, done, illegal, int_window, refresh;
  logic mem_valid, mem_ready, mem_rvalid, mem_rready;
  logic [3:0] done_mcycles;
  logic [7:0] mem_rdata;
  ebx_mem_req_t mem_req;
  int rd_pushes = 0;
  int rd_full = 0;
  logic got_ill, got_iw;
  int refs;
  int failures = 0;
  int total_checks = 0;

  always #2 mclk = ~mclk;

  ebx_exec #(.FIFO_DEPTH(4)) dut (.mclk, .resetn, .regs_load, .regs_in, .regs, .cmd_valid, .cmd_ready,
    .cmd_prefix, .cmd_opcode, .done, .done_mcycles, .illegal, .int_window, .refresh, .mem_valid,
    .mem_ready, .mem_req, .mem_rvalid, .mem_rready, .mem_rdata);
  ebx_mem_model mem_m (.mclk, .resetn, .slow, .mem_valid, .mem_ready, .mem_req, .mem_rvalid,
    .mem_rready, .mem_rdata);

  // Return-buffer traffic, counted where it is settled
  always @(negedge mclk)
  begin
    rd_pushes += int'(mem_rvalid === 1'b1 && mem_rready === 1'b1);
    rd_full += int'(mem_rready !== 1'b1);
  end

  task automatic chk(input logic [191:0] got, input logic [191:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic load(input ebx_regs_t v);
    @(negedge mclk);
    regs_load = 1'b1;
    regs_in = v;
    @(negedge mclk);
    regs_load = 1'b0;
    e = v;
  endtask

  task automatic run(input logic [7:0] p, input logic [7:0] o);
    int n;
    n = 0;
    refs = 0;
    @(negedge mclk);
    while (cmd_ready !== 1'b1)
      @(negedge mclk);
    cmd_valid = 1'b1;
    cmd_prefix = p;
    cmd_opcode = o;
    @(negedge mclk);
    cmd_valid = 1'b0;
    while (done !== 1'b1 && illegal !== 1'b1 && n < 200)
    begin
      refs += int'(refresh === 1'b1);
      n++;
      @(negedge mclk);
    end
    refs += int'(refresh === 1'b1);
    got_ill = illegal;
    got_iw = int_window;
    chk(n < 200, 1'b1);
  endtask

  task automatic t_swaps();
    ebx_regs_t r;
    r = '0;
    r.accum_flags_pair = 16'h9900;
    r.shadow_accum_flags_pair = 16'h5944;
    r.byte_count_pair = 16'h445a;
    r.target_ptr_pair = 16'h3da2;
    r.source_pair = 16'h8859;
    r.shadow_byte_count_pair = 16'h0988;
    r.shadow_target_ptr_pair = 16'h9300;
    r.shadow_source_pair = 16'h00e7;
    load(r);
    run(PFX_NONE, OP_SWAP_PAIRS);
    e.target_ptr_pair = 16'h8859;
    e.source_pair = 16'h3da2;
    chk(regs, e);
    chk(done_mcycles, 4'h1);
    run(PFX_NONE, OP_SWAP_AF);
    e.accum_flags_pair = 16'h5944;
    e.shadow_accum_flags_pair = 16'h9900;
    chk(regs, e);
    r = e;
    run(PFX_NONE, OP_BANK_SWAP);
    e.byte_count_pair = r.shadow_byte_count_pair;
    e.shadow_byte_count_pair = r.byte_count_pair;
    e.target_ptr_pair = r.shadow_target_ptr_pair;
    e.shadow_target_ptr_pair = r.target_ptr_pair;
    e.source_pair = r.shadow_source_pair;
    e.shadow_source_pair = r.source_pair;
    chk(regs, e);
  endtask

  task automatic t_stack(input logic [7:0] p, input logic s);
    ebx_regs_t r;
    logic [15:0] old;
    r = '0;
    r.accum_flags_pair = 16'h00d7;
    r.stack_ptr = 16'h8856;
    r.source_pair = 16'h7012;
    r.first_offset_reg = 16'h3988;
    r.second_offset_reg = 16'h4501;
    mem_m.mem[16'h8856] = 8'h11;
    mem_m.mem[16'h8857] = 8'h22;
    slow = s;
    load(r);
    run(p, OP_STACK_SWAP);
    old = (p == PFX_FIRST) ? 16'h3988 : (p == PFX_SECOND) ? 16'h4501 : 16'h7012;
    if (p == PFX_FIRST)
      e.first_offset_reg = 16'h2211;
    else if (p == PFX_SECOND)
      e.second_offset_reg = 16'h2211;
    else
      e.source_pair = 16'h2211;
    chk(regs, e);
    chk(mem_m.mem[16'h8856], old[7:0]);
    chk(mem_m.mem[16'h8857], old[15:8]);
    chk(done_mcycles, (p == PFX_NONE) ? 4'h5 : 4'h6);
    slow = 1'b0;
  endtask

  task automatic t_copy(input logic [15:0] cnt, input logic [15:0] fl);
    ebx_regs_t r;
    r = '0;
    r.accum_flags_pair = 16'h00ff;
    r.source_pair = 16'h1111;
    r.target_ptr_pair = 16'h2222;
    r.byte_count_pair = cnt;
    r.prog_ctr = 16'h0200;
    mem_m.mem[16'h1111] = 8'h88;
    mem_m.mem[16'h2222] = 8'h66;
    load(r);
    run(PFX_EXT, OP_COPY_INC);
    e.source_pair = 16'h1112;
    e.target_ptr_pair = 16'h2223;
    e.byte_count_pair = cnt - 16'h1;
    e.accum_flags_pair = fl;
    chk(regs, e);
    chk(mem_m.mem[16'h2222], 8'h88);
    chk(done_mcycles, 4'h4);
  endtask

  task automatic t_repeat();
    ebx_regs_t r;
    r = '0;
    r.accum_flags_pair = 16'h00ff;
    r.source_pair = 16'h1111;
    r.target_ptr_pair = 16'h2222;
    r.byte_count_pair = 16'h0003;
    r.prog_ctr = 16'h0200;
    mem_m.mem[16'h1111] = 8'h88;
    mem_m.mem[16'h1112] = 8'h36;
    mem_m.mem[16'h1113] = 8'ha5;
    load(r);
    for (int i = 0; i < 3; i++)
    begin
      run(PFX_EXT, OP_COPY_INC_REPEAT);
      e.source_pair++;
      e.target_ptr_pair++;
      e.byte_count_pair--;
      e.accum_flags_pair = 16'h00e9;
      if (i < 2)
        e.prog_ctr -= 16'h2;
      chk(regs, e);
      chk(done_mcycles, (i < 2) ? 4'h5 : 4'h4);
      chk(refs, (i < 2) ? 2 : 0);
      if (i < 2)
        chk(got_iw, 1'b1);
    end
    chk({mem_m.mem[16'h2222], mem_m.mem[16'h2223], mem_m.mem[16'h2224]}, 24'h8836a5);
    e.byte_count_pair = 16'h0000;
    load(e);
    run(PFX_EXT, OP_COPY_INC_REPEAT);
    chk(regs.byte_count_pair, 16'hffff);
    chk(done_mcycles, 4'h5);
  endtask

  task automatic t_illegal();
    load(e);
    run(PFX_NONE, OP_COPY_INC_REPEAT);
    chk(got_ill, 1'b1);
    chk(regs, e);
    run(PFX_EXT, OP_STACK_SWAP);
    chk(got_ill, 1'b1);
    chk(regs, e);
  endtask

  // Each stack read crosses the return buffer exactly once and leaves it empty
  task automatic t_fifo();
    int pushes;
    int full;
    pushes = rd_pushes;
    full = rd_full;
    chk(mem_rready, 1'b1);
    t_stack(PFX_FIRST, 1'b1);
    chk(rd_pushes - pushes, 2);
    chk(rd_full - full, 0);
    chk(mem_rready, 1'b1);
    chk(dut.rd_valid, 1'b0);
  endtask

  task automatic end_of_test();
    $display("Checks %0d, failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    repeat (6) @(negedge mclk);
    resetn = 1'b1;
    chk(regs, '0);
    chk(cmd_ready, 1'b1);
    t_swaps();
    t_stack(PFX_NONE, 1'b0);
    t_stack(PFX_FIRST, 1'b0);
    t_stack(PFX_SECOND, 1'b1);
    t_copy(16'h0007, 16'h00ed);
    t_copy(16'h0001, 16'h00e9);
    t_repeat();
    t_illegal();
    t_fifo();
    end_of_test();
  end

  // A few hundred cycles are needed; this cuts a hang short
  initial
  begin
    #40000;
    failures++;
    end_of_test();
  end
endmodule
`default_nettype wire
